// ---- hdl/pps_consts.svh ----
// Constants of the port parameter store: offsets, codes, field values and counts.
// Assumes inclusion by the package, by the design file and by the test bench.
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH
// =====================================================================
// Register byte offsets and register group codes
`define PPS_OFF_CMD 8'h00
`define PPS_OFF_GO 8'h04
`define PPS_OFF_CSTAT 8'h08
`define PPS_OFF_RIDX 8'h0c
`define PPS_OFF_RDATA 8'h10
`define PPS_OFF_VERR 8'h14
`define PPS_GRP_GLOB 3'h0
`define PPS_GRP_PCFG 3'h1
`define PPS_GRP_VID 3'h2
`define PPS_GRP_DID 3'h3
// =====================================================================
// Command codes
`define PPS_ATTR 8'h05
`define PPS_AC_SEG1 8'h05
`define PPS_AC_SEG2 8'h06
`define PPS_AC_SEG3 8'h07
`define PPS_AC_STAT 8'h0d
`define PPS_TG_ALL 8'h00
`define PPS_TG_LAST 8'h08
`define PPS_ERR_CODE 16'hc050
`define PPS_OK_CODE 16'h0000
// =====================================================================
// Word counts and archive layout
`define PPS_N_ALL 16'h0028
`define PPS_N_ONE 16'h0005
`define PPS_SEG12_MAX 16'h0156
`define PPS_SEG3_MAX 16'h0154
`define PPS_SEG2_BASE 10'h156
`define PPS_SEG3_BASE 10'h2ac
`define PPS_REC_W 10'h005
// =====================================================================
// Field encodings
`define PPS_VT_OFF 4'h0
`define PPS_VT_V11 4'h2
`define PPS_VT_BR 4'h3
`define PPS_VT_RO 4'h4
`define PPS_LM_INACT 4'h0
`define PPS_LM_LINK 4'h1
`define PPS_LM_SDI 4'h3
`define PPS_LM_SDO 4'h4
`define PPS_AT_NONE 8'h00
`define PPS_AT_ABN 8'h40
`define PPS_AT_PRE 8'h80
`define PPS_AT_OP 8'hff
`define PPS_RESP_OK 2'h0
`define PPS_RESP_ERR 2'h2
`endif

// ---- hdl/pps_pkg.sv ----
// Types shared by the port parameter store and its surroundings.
// Assumes pps_consts.svh is on the include path.
package pps_pkg;
  `include "pps_consts.svh"
  // Live link state of one port; poll is the link cycle in 100 us steps
  typedef struct packed {
    logic [7:0] attach;
    logic [7:0] baud_code;
    logic [7:0] poll;
    logic [15:0] vid;
    logic [23:0] did;
  } pps_lkstat_t;
  // Parameter word captured from a field device
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [9:0] idx;
    logic [15:0] data;
  } pps_lkwr_t;
  // Per-port configuration, low twelve bits of the config register
  typedef struct packed {
    logic [3:0] aux_input_mode;
    logic [3:0] line_mode;
    logic [3:0] vtype;
  } pps_pcfg_t;
  typedef enum logic [1:0] {ck_none, ck_arc, ck_stat} pps_ckind_t;
endpackage

// ---- hdl/pps_port_store.sv ----
// Port parameter store: identity validation, archive backup/restore, read commands.
// Assumes an AXI4-Lite master and a link engine that feeds port state and parameters.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pps_consts.svh"

// Notes on behaviour
// - With validation on, compare held vendor/device ids with the attached device's.
// - Differing ids set a validation error flag for that port.
// - In either archive mode, copy device parameters into the port archive.
// - Backup-plus-restore: local parameter changes overwrite the archive.
// - Restore-only: local changes are undone by writing the archive back; a change with another port's start-up in one cycle is not restored.
// - Either archive mode: device starting with differing parameters gets the archive.
// - Erase archive on switching mode, type 0 to 2, or changed ids; a type or id write while a word for that port is captured keeps it.
// - A validation mismatch suppresses backup and restore for that port.
// - Archive read: attribute 5, access 5/6/7 per segment, port 1 to 8.
// - Archive segments return at most 342, 342 and 340 words.
// - Archive packed contiguously: first segment, then second, then third.
// - Archive reads zero unless link mode with archive, or standby after link.
// - Status read: attribute 5, access 0x0d, target 0 all, 1 to 8 one.
// - Status read returns 40 words for all ports, 5 for one.
// - Word 0: aux mode, line mode, port number; word 1: baud, poll period.
// - All-ports status places five-word records in port order.
// - Validation type: 0 off, 1 and 2 validate, 3 backup, 4 restore.
// - Line mode: 0 inactive, 1 link, 3 switching input, 4 switching output.
// - Attach state: 0 none, 0x40 abnormal, 0x80 pre-operation, 0xff operating.
// - Poll period in 100 us steps; link fields zero outside link mode.
module pps_port_store (
  input logic aclk, // Clock, 100 MHz
  input logic aresetn, // Synchronous reset, active low
  input logic [7:0] awaddr, // Write address
  input logic [2:0] awprot, // Write protection, unused
  input logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input logic [31:0] wdata, // Write data
  input logic [3:0] wstrb, // Write byte strobes
  input logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input logic bready, // Write response ready
  input logic [7:0] araddr, // Read address
  input logic [2:0] arprot, // Read protection, unused
  input logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input logic rready, // Read data ready
  input pps_pkg::pps_lkstat_t [7:0] lk_stat, // Live link state per port
  input pps_pkg::pps_lkwr_t lk_wr, // Parameter word from a field device
  input logic lk_chg_valid, // Local parameter change seen
  input logic [2:0] lk_chg_port, // Port of that change
  input logic lk_up_valid, // Device started with differing parameters
  input logic [2:0] lk_up_port, // Port of that start-up
  output logic rs_valid, // Restore archive into device, pulse
  output logic [2:0] rs_port, // Port to restore
  input logic [2:0] arc_rd_port, // Archive fetch port for restore
  input logic [9:0] arc_rd_idx, // Archive fetch word index
  output logic [15:0] arc_rd_data, // Archive fetch data, one cycle later
  output logic [7:0] val_err // Validation error flags
);
  import pps_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic arch_mode(input logic [3:0] vt);
    return (vt == `PPS_VT_BR) || (vt == `PPS_VT_RO);
  endfunction

  // ===================================================================
  // State
  logic [15:0] arc_mem [0:8191];
  pps_pcfg_t pcfg_r [8];
  logic [15:0] vid_r [8];
  logic [23:0] did_r [8];
  logic [7:0] verr_r, verr_nxt, has_r, has_nxt, ever_r, ever_nxt, erase_w;
  logic [23:0] cmd_r;
  pps_ckind_t ck_r;
  logic [15:0] code_r, cnt_r, arc_rd_data_r;
  logic [9:0] ridx_r;
  logic bvalid_r, rvalid_r, rs_valid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [2:0] rs_port_r;
  logic wr_run_r;
  logic [2:0] wr_prt_r;

  // ===================================================================
  // Bus decode
  wire wr_fire = awvalid && wvalid && !bvalid_r;
  wire ar_fire = arvalid && !rvalid_r;
  wire [2:0] wgrp = awaddr[7:5];
  wire [2:0] wprt = awaddr[4:2];
  wire [2:0] rgrp = araddr[7:5];
  wire [2:0] rprt = araddr[4:2];
  wire w_glob = wgrp == `PPS_GRP_GLOB;
  wire w_cmd = wr_fire && w_glob && awaddr[4:0] == 5'(`PPS_OFF_CMD);
  wire w_go = wr_fire && w_glob && awaddr[4:0] == 5'(`PPS_OFF_GO);
  wire w_ridx = wr_fire && w_glob && awaddr[4:0] == 5'(`PPS_OFF_RIDX);
  wire w_map = w_glob ? (awaddr[4:0] <= 5'(`PPS_OFF_VERR)) : (wgrp <= `PPS_GRP_DID);
  wire r_map = rgrp == `PPS_GRP_GLOB ? (araddr[4:0] <= 5'(`PPS_OFF_VERR))
                                      : (rgrp <= `PPS_GRP_DID);
  wire [31:0] cfg_new = wmerge({20'h0, pcfg_r[wprt]}, wdata, wstrb);
  wire [31:0] vid_new = wmerge({16'h0, vid_r[wprt]}, wdata, wstrb);
  wire [31:0] did_new = wmerge({8'h0, did_r[wprt]}, wdata, wstrb);
  wire [31:0] cmd_new = wmerge({8'h0, cmd_r}, wdata, wstrb);
  wire [31:0] ridx_new = wmerge({22'h0, ridx_r}, wdata, wstrb);
  wire w_cfg = wr_fire && wgrp == `PPS_GRP_PCFG;
  wire w_vid = wr_fire && wgrp == `PPS_GRP_VID;
  wire w_did = wr_fire && wgrp == `PPS_GRP_DID;
  wire [3:0] new_vt = cfg_new[3:0];
  wire [3:0] new_lm = cfg_new[7:4];

  // ===================================================================
  // Validation, archive capture and restore triggers
  logic [7:0] mism_w;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      mism_w[p] = pcfg_r[p].vtype != `PPS_VT_OFF && pcfg_r[p].vtype <= `PPS_VT_RO
        && lk_stat[p].attach != `PPS_AT_NONE
        && (lk_stat[p].vid != vid_r[p] || lk_stat[p].did != did_r[p]);
      erase_w[p] = pcfg_r[p].line_mode == `PPS_LM_SDI || pcfg_r[p].line_mode == `PPS_LM_SDO
        || (w_cfg && wprt == 3'(p) && (new_vt <= `PPS_VT_V11 || new_lm == `PPS_LM_SDI
                                        || new_lm == `PPS_LM_SDO))
        || (w_vid && wprt == 3'(p) && vid_new[15:0] != vid_r[p])
        || (w_did && wprt == 3'(p) && did_new[23:0] != did_r[p]);
    end
  end

  wire [2:0] wp = lk_wr.port;
  // Restore-only locks the archive only once a whole upload has been taken
  wire wr_cont = wr_run_r && wr_prt_r == wp;
  wire wr_ok = lk_wr.valid && arch_mode(pcfg_r[wp].vtype) && !verr_r[wp]
    && pcfg_r[wp].line_mode == `PPS_LM_LINK
    && (pcfg_r[wp].vtype == `PPS_VT_BR || !has_r[wp] || wr_cont);
  wire up_ok = lk_up_valid && arch_mode(pcfg_r[lk_up_port].vtype) && !verr_r[lk_up_port]
    && has_r[lk_up_port];
  wire chg_ok = lk_chg_valid && pcfg_r[lk_chg_port].vtype == `PPS_VT_RO
    && !verr_r[lk_chg_port] && has_r[lk_chg_port];

  always_comb begin
    verr_nxt = mism_w;
    has_nxt = has_r & ~erase_w;
    ever_nxt = ever_r & ~erase_w;
    for (int p = 0; p < 8; p++) begin
      if (pcfg_r[p].line_mode == `PPS_LM_LINK && arch_mode(pcfg_r[p].vtype)) begin
        ever_nxt[p] = 1'b1;
      end
    end
    if (wr_ok) begin
      has_nxt[wp] = 1'b1;
    end
  end

  // Archive: word index runs through the three segments without gaps
  always_ff @(posedge aclk) begin
    if (wr_ok) begin
      arc_mem[{wp, lk_wr.idx}] <= lk_wr.data;
    end
    arc_rd_data_r <= arc_mem[{arc_rd_port, arc_rd_idx}];
  end

  // ===================================================================
  // Command decode
  wire [7:0] c_attr = cmd_r[23:16];
  wire [7:0] c_ac = cmd_r[15:8];
  wire [7:0] c_tg = cmd_r[7:0];
  wire tg_one = c_tg != `PPS_TG_ALL && c_tg <= `PPS_TG_LAST;
  wire is_arc = c_attr == `PPS_ATTR && c_ac >= `PPS_AC_SEG1 && c_ac <= `PPS_AC_SEG3
    && tg_one;
  wire is_st = c_attr == `PPS_ATTR && c_ac == `PPS_AC_STAT
    && (tg_one || c_tg == `PPS_TG_ALL);
  wire [15:0] n_cmd = is_st ? (c_tg == `PPS_TG_ALL ? `PPS_N_ALL : `PPS_N_ONE)
    : (c_ac == `PPS_AC_SEG3 ? `PPS_SEG3_MAX : `PPS_SEG12_MAX);
  wire [2:0] tgp = 3'(c_tg - 8'h01);

  // ===================================================================
  // Result words
  wire [9:0] seg_base = c_ac == `PPS_AC_SEG3 ? `PPS_SEG3_BASE
    : (c_ac == `PPS_AC_SEG2 ? `PPS_SEG2_BASE : 10'h000);
  wire [9:0] arc_a = seg_base + ridx_r;
  wire [3:0] tlm = pcfg_r[tgp].line_mode;
  wire arc_ok = has_r[tgp] && ((tlm == `PPS_LM_LINK && arch_mode(pcfg_r[tgp].vtype))
    || (tlm == `PPS_LM_INACT && ever_r[tgp]));
  wire in_rng = {6'h00, ridx_r} < cnt_r;
  wire [15:0] arc_word = arc_mem[{tgp, arc_a}];
  wire all_tg = c_tg == `PPS_TG_ALL;
  wire [9:0] rec = ridx_r / `PPS_REC_W;
  wire [2:0] sp = all_tg ? rec[2:0] : tgp;
  wire [2:0] sw = all_tg ? 3'(ridx_r - rec * `PPS_REC_W) : ridx_r[2:0];
  wire sp_link = pcfg_r[sp].line_mode == `PPS_LM_LINK;
  pps_lkstat_t ls;
  assign ls = sp_link ? lk_stat[sp] : '0;
  logic [15:0] st_word;
  always_comb begin
    case (sw)
      3'h0: st_word = {pcfg_r[sp].aux_input_mode, pcfg_r[sp].line_mode,
                       8'(sp) + 8'h01};
      3'h1: st_word = {ls.baud_code, ls.poll};
      3'h2: st_word = {ls.vid[15:8], ls.attach};
      3'h3: st_word = {ls.did[23:16], ls.vid[7:0]};
      3'h4: st_word = {ls.did[7:0], ls.did[15:8]};
      default: st_word = 16'h0000;
    endcase
  end
  logic [15:0] res_word;
  always_comb begin
    case (ck_r)
      ck_arc: res_word = (arc_ok && in_rng) ? arc_word : 16'h0000;
      ck_stat: res_word = in_rng ? st_word : 16'h0000;
      default: res_word = 16'h0000;
    endcase
  end

  // ===================================================================
  // Register read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (rgrp)
      `PPS_GRP_PCFG: rd_mux = {20'h0, pcfg_r[rprt]};
      `PPS_GRP_VID: rd_mux = {16'h0, vid_r[rprt]};
      `PPS_GRP_DID: rd_mux = {8'h0, did_r[rprt]};
      `PPS_GRP_GLOB: begin
        case (araddr[4:0])
          5'(`PPS_OFF_CMD): rd_mux = {8'h0, cmd_r};
          5'(`PPS_OFF_CSTAT): rd_mux = {code_r, cnt_r};
          5'(`PPS_OFF_RIDX): rd_mux = {22'h0, ridx_r};
          5'(`PPS_OFF_RDATA): rd_mux = {16'h0, res_word};
          5'(`PPS_OFF_VERR): rd_mux = {24'h0, verr_r};
          default: rd_mux = 32'h0;
        endcase
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // ===================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < 8; p++) begin
        pcfg_r[p] <= '0;
        vid_r[p] <= 16'h0000;
        did_r[p] <= 24'h000000;
      end
      {verr_r, has_r, ever_r} <= 24'h000000;
      cmd_r <= 24'h000000;
      ck_r <= ck_none;
      {code_r, cnt_r} <= 32'h0;
      ridx_r <= 10'h000;
      wr_run_r <= 1'b0;
      wr_prt_r <= 3'h0;
    end else begin
      wr_run_r <= wr_ok;
      wr_prt_r <= wp;
      verr_r <= verr_nxt;
      has_r <= has_nxt;
      ever_r <= ever_nxt;
      if (w_cfg) pcfg_r[wprt] <= cfg_new[11:0];
      if (w_vid) vid_r[wprt] <= vid_new[15:0];
      if (w_did) did_r[wprt] <= did_new[23:0];
      if (w_cmd) cmd_r <= cmd_new[23:0];
      if (w_ridx) ridx_r <= ridx_new[9:0];
      if (w_go) begin
        ck_r <= is_arc ? ck_arc : (is_st ? ck_stat : ck_none);
        code_r <= (is_arc || is_st) ? `PPS_OK_CODE : `PPS_ERR_CODE;
        cnt_r <= (is_arc || is_st) ? n_cmd : 16'h0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {bvalid_r, rvalid_r, rs_valid_r} <= 3'h0;
      {bresp_r, rresp_r} <= 4'h0;
      rdata_r <= 32'h0;
      rs_port_r <= 3'h0;
    end else begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= w_map ? `PPS_RESP_OK : `PPS_RESP_ERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rresp_r <= r_map ? `PPS_RESP_OK : `PPS_RESP_ERR;
        rdata_r <= rd_mux;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
      rs_valid_r <= up_ok || chg_ok;
      rs_port_r <= up_ok ? lk_up_port : lk_chg_port;
    end
  end

  assign awready = wr_fire;
  assign wready = wr_fire;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign rs_valid = rs_valid_r;
  assign rs_port = rs_port_r;
  assign arc_rd_data = arc_rd_data_r;
  assign val_err = verr_r;

  // ===================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_VAL_FLAG: assert property (mism_w[0] |=> val_err[0])
    else $error("validation mismatch not flagged");
  AST_VAL_CLEAR: assert property (!mism_w[0] |=> !val_err[0])
    else $error("validation flag without mismatch");
  AST_BACKUP: assert property (wr_ok |=> has_r[$past(wp)])
    else $error("archive capture not recorded");
  AST_RO_LOCK: assert property (pcfg_r[wp].vtype == `PPS_VT_RO && has_r[wp] && !wr_cont
    |-> !wr_ok) else $error("restore-only archive overwritten");
  AST_RESTORE: assert property (chg_ok && !up_ok |=>
    rs_valid && rs_port == $past(lk_chg_port)) else $error("local change not restored");
  AST_STARTUP: assert property (up_ok |=> rs_valid ##1 !rs_valid)
    else $error("start-up restore missing or long");
  AST_ERASE: assert property (erase_w[0] && !(wr_ok && wp == 3'h0) |=> !has_r[0])
    else $error("archive not erased");
  AST_SKIP: assert property (verr_r[lk_up_port] && lk_up_valid && !chg_ok |=> !rs_valid)
    else $error("restore on mismatched device");
  AST_CNT_ALL: assert property (w_go && is_st && c_tg == `PPS_TG_ALL
    |=> cnt_r == 16'h0028) else $error("all-port status count wrong");
  AST_BAD_CMD: assert property (w_go && !is_arc && !is_st |=> code_r == `PPS_ERR_CODE
    && cnt_r == 16'h0000) else $error("bad command accepted");
  AST_ARC_ZERO: assert property (ar_fire && ck_r == ck_arc && !arc_ok
    && araddr == `PPS_OFF_RDATA |=> rdata == 32'h0) else $error("archive read not zero");
  COV_STAT_ALL: cover property (w_go && is_st && c_tg == `PPS_TG_ALL);
  COV_ARC_SEG3: cover property (w_go && is_arc && c_ac == `PPS_AC_SEG3);
  COV_RESTORE: cover property (rs_valid);
  COV_VERR: cover property (val_err != 8'h00);
endmodule

// ---- verif/pps_link_model.sv ----
// Stand-in for the link engine and the field devices behind the parameter store.
// Assumes pps_pkg is compiled first; the bench calls its tasks and sets lk_stat.
`timescale 1ns/1ps
module pps_link_model (
  input wire logic aclk, // Clock
  output pps_pkg::pps_lkstat_t [7:0] lk_stat, // Live port state
  output pps_pkg::pps_lkwr_t lk_wr, // Parameter word from a device
  output logic lk_chg_valid, // Local change pulse
  output logic [2:0] lk_chg_port, // Port of the change
  output logic lk_up_valid, // Start-up pulse
  output logic [2:0] lk_up_port, // Port of the start-up
  input wire logic rs_valid, // Restore request
  input wire logic [2:0] rs_port, // Port to restore
  output logic [2:0] arc_rd_port, // Archive fetch port
  output logic [9:0] arc_rd_idx, // Archive fetch index
  input wire logic [15:0] arc_rd_data // Archive fetch data
);
  import pps_pkg::*;
  logic [15:0] dev [8][2];
  logic [2:0] rp;
  int rs_cnt = 0;
  initial begin
    lk_stat = '0;
    lk_wr = '0;
    {lk_chg_valid, lk_chg_port, lk_up_valid, lk_up_port} = '0;
    {arc_rd_port, arc_rd_idx} = '0;
  end
  // ====
  // Device parameter upload, one word a cycle
  task automatic send(input int p, input int base);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      lk_wr <= '{1'b1, 3'(p), 10'(base + i), dev[p][i]};
    end
    @(posedge aclk);
    lk_wr <= '0;
  endtask
  task automatic pulse(input bit up, input int p);
    @(posedge aclk);
    if (up) begin
      lk_up_valid <= 1'b1;
      lk_up_port <= 3'(p);
    end else begin
      lk_chg_valid <= 1'b1;
      lk_chg_port <= 3'(p);
    end
    @(posedge aclk);
    lk_up_valid <= 1'b0;
    lk_chg_valid <= 1'b0;
  endtask
  // ====
  // Restore: fetch archived words back into the device
  always begin
    @(negedge aclk);
    if (rs_valid === 1'b1) begin
      rs_cnt++;
      rp = rs_port;
      for (int i = 0; i < 2; i++) begin
        @(posedge aclk);
        arc_rd_port <= rp;
        arc_rd_idx <= 10'(i);
        @(posedge aclk);
        @(negedge aclk);
        dev[rp][i] = arc_rd_data;
      end
    end
  end
endmodule

// ---- verif/pps_port_store_test.sv ----
// Self-checking bench for the port parameter store, with a reference model.
// Assumes pps_pkg, pps_port_store and pps_link_model are compiled first.
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_port_store_test;
  import pps_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, rs_valid, lk_chg_valid, lk_up_valid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  pps_lkstat_t [7:0] lk_stat;
  pps_lkwr_t lk_wr;
  logic [2:0] lk_chg_port, lk_up_port, rs_port, arc_rd_port;
  logic [9:0] arc_rd_idx;
  logic [15:0] arc_rd_data;
  logic [7:0] val_err;
  logic [31:0] seed = 32'h1a3f;
  logic [3:0] line_m [8];
  logic [3:0] aux_m [8];
  bit has_m [8];
  int arc_m [int];
  int err_count = 0;
  int total_checks = 0;
  int cnt;
  always #5 aclk = ~aclk;

  pps_port_store u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .lk_stat(lk_stat), .lk_wr(lk_wr),
    .lk_chg_valid(lk_chg_valid), .lk_chg_port(lk_chg_port), .lk_up_valid(lk_up_valid),
    .lk_up_port(lk_up_port), .rs_valid(rs_valid), .rs_port(rs_port),
    .arc_rd_port(arc_rd_port), .arc_rd_idx(arc_rd_idx), .arc_rd_data(arc_rd_data),
    .val_err(val_err));
  pps_link_model u_lm (.aclk(aclk), .lk_stat(lk_stat), .lk_wr(lk_wr),
    .lk_chg_valid(lk_chg_valid), .lk_chg_port(lk_chg_port), .lk_up_valid(lk_up_valid),
    .lk_up_port(lk_up_port), .rs_valid(rs_valid), .rs_port(rs_port),
    .arc_rd_port(arc_rd_port), .arc_rd_idx(arc_rd_idx), .arc_rd_data(arc_rd_data));

  // ====
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] ac, input logic [7:0] tg, input logic [31:0] exp);
    wr(`PPS_OFF_CMD, {8'h00, `PPS_ATTR, ac, tg});
    wr(`PPS_OFF_GO, 32'h1);
    rd(`PPS_OFF_CSTAT);
    chk(rd_v, exp, "completion");
  endtask
  task automatic word(input int i, input logic [15:0] exp);
    wr(`PPS_OFF_RIDX, 32'(i));
    rd(`PPS_OFF_RDATA);
    chk(rd_v, {16'h0, exp}, "result word");
  endtask
  task automatic pcfg(input int p, input logic [3:0] aux, input logic [3:0] ln,
                      input logic [3:0] vt);
    aux_m[p] = aux;
    line_m[p] = ln;
    wr(8'(8'h20 + 4 * p), {20'h0, aux, ln, vt});
  endtask
  task automatic ids(input int p, input logic [15:0] vx);
    wr(8'(8'h40 + 4 * p), {16'h0, lk_stat[p].vid ^ vx});
    wr(8'(8'h60 + 4 * p), {8'h0, lk_stat[p].did});
  endtask
  task automatic stat(input int p, input logic [7:0] at);
    @(posedge aclk);
    u_lm.lk_stat[p] <= '{at, 8'(xs() % 3), 8'(xs()), 16'(xs()), 24'(xs())};
    @(posedge aclk);
  endtask
  task automatic snd(input int p, input int base, input bit keep);
    u_lm.send(p, base);
    for (int i = 0; i < 2; i++) if (keep) arc_m[p * 1024 + base + i] = u_lm.dev[p][i];
  endtask
  task automatic arc_chk(input int p, input logic [7:0] ac, input int base,
                         input logic [15:0] n);
    cmd(ac, 8'(p + 1), {`PPS_OK_CODE, n});
    for (int i = 0; i < 2; i++) word(i, has_m[p] ? 16'(arc_m[p * 1024 + base + i]) : 16'h0);
  endtask
  function automatic logic [15:0] st_w(input int p, input int k);
    pps_lkstat_t s;
    s = (line_m[p] == `PPS_LM_LINK) ? lk_stat[p] : '0;
    case (k)
      0: return {aux_m[p], line_m[p], 8'(p + 1)};
      1: return {s.baud_code, s.poll};
      2: return {s.vid[15:8], s.attach};
      3: return {s.did[23:16], s.vid[7:0]};
      default: return {s.did[7:0], s.did[15:8]};
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ====
  // Watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  // ====
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PPS_OFF_VERR);
    chk(rd_v, 32'h0, "flags after reset");
    rd(8'h18);
    chk({30'h0, rsp}, {30'h0, `PPS_RESP_ERR}, "unmapped read");
    wr(8'h80, 32'h0);
    chk({30'h0, rsp}, {30'h0, `PPS_RESP_ERR}, "unmapped write");
    $display("register test done");
    stat(0, `PPS_AT_OP);
    ids(0, 16'h0);
    chk({30'h0, rsp}, {30'h0, `PPS_RESP_OK}, "mapped write");
    pcfg(0, 4'h0, `PPS_LM_LINK, `PPS_VT_BR);
    u_lm.dev[0][0] = 16'(xs());
    u_lm.dev[0][1] = 16'(xs());
    has_m[0] = 1;
    for (int b = 0; b < 3; b++) snd(0, b * 342, 1);
    arc_chk(0, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    arc_chk(0, `PPS_AC_SEG2, 342, `PPS_SEG12_MAX);
    arc_chk(0, `PPS_AC_SEG3, 684, `PPS_SEG3_MAX);
    chk({24'h0, val_err}, 32'h0, "no mismatch flag");
    cnt = u_lm.rs_cnt;
    u_lm.dev[0][0] = ~u_lm.dev[0][0];
    u_lm.pulse(0, 0);
    snd(0, 0, 1);
    repeat (12) @(posedge aclk);
    chk(32'(u_lm.rs_cnt), 32'(cnt), "backup mode restore");
    arc_chk(0, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    pcfg(0, 4'h0, `PPS_LM_INACT, `PPS_VT_BR);
    arc_chk(0, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    pcfg(0, 4'h0, `PPS_LM_SDI, `PPS_VT_BR);
    has_m[0] = 0;
    arc_chk(0, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    $display("backup test done");
    stat(1, `PPS_AT_OP);
    ids(1, 16'h0);
    pcfg(1, 4'h0, `PPS_LM_LINK, `PPS_VT_RO);
    u_lm.dev[1][0] = 16'(xs());
    u_lm.dev[1][1] = 16'(xs());
    has_m[1] = 1;
    snd(1, 0, 1);
    u_lm.dev[1][0] = ~u_lm.dev[1][0];
    u_lm.pulse(0, 1);
    repeat (12) @(posedge aclk);
    chk({16'h0, u_lm.dev[1][0]}, 32'(arc_m[1024]), "restore after change");
    u_lm.dev[1][1] = ~u_lm.dev[1][1];
    u_lm.pulse(1, 1);
    repeat (12) @(posedge aclk);
    chk({16'h0, u_lm.dev[1][1]}, 32'(arc_m[1025]), "restore at start-up");
    stat(1, `PPS_AT_OP);
    ids(1, 16'h0);
    has_m[1] = 0;
    arc_chk(1, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    $display("restore test done");
    stat(2, `PPS_AT_PRE);
    ids(2, 16'h5a5a);
    pcfg(2, 4'h0, `PPS_LM_LINK, `PPS_VT_BR);
    repeat (3) @(posedge aclk);
    chk({24'h0, val_err}, 32'h4, "mismatch flag");
    rd(`PPS_OFF_VERR);
    chk(rd_v, 32'h4, "mismatch register");
    snd(2, 0, 0);
    arc_chk(2, `PPS_AC_SEG1, 0, `PPS_SEG12_MAX);
    ids(2, 16'h0);
    repeat (3) @(posedge aclk);
    chk({24'h0, val_err}, 32'h0, "flag cleared");
    $display("validation test done");
    cmd(8'h08, 8'h01, {`PPS_ERR_CODE, 16'h0});
    cmd(`PPS_AC_SEG1, 8'h09, {`PPS_ERR_CODE, 16'h0});
    cmd(`PPS_AC_STAT, 8'h09, {`PPS_ERR_CODE, 16'h0});
    word(0, 16'h0);
    $display("refusal test done");
    for (int p = 0; p < 8; p++) begin
      stat(p, 8'({8'h00, 8'h40, 8'h80, 8'hff} >> (8 * (xs() % 4))));
      pcfg(p, 4'(xs() % 2), 4'({4'h0, 4'h1, 4'h3, 4'h4} >> (4 * (p % 4))), 4'h0);
    end
    cmd(`PPS_AC_STAT, `PPS_TG_ALL, {`PPS_OK_CODE, `PPS_N_ALL});
    for (int p = 0; p < 8; p++)
      for (int k = 0; k < 5; k++) word(5 * p + k, st_w(p, k));
    for (int p = 0; p < 8; p++) begin
      cmd(`PPS_AC_STAT, 8'(p + 1), {`PPS_OK_CODE, `PPS_N_ONE});
      for (int k = 0; k < 5; k++) word(k, st_w(p, k));
    end
    $display("status test done");
    test_done();
  end
endmodule
